/* File: core/qcs_defines.svh */
// Purpose: Constants of the quadrature counter with serial configuration
// Assumes: Included by the package and the counter module
// Notes: Bit positions refer to the 32-bit configuration word, except the gear bits of the threshold
`ifndef QCS_DEFINES_SVH
`define QCS_DEFINES_SVH

`define QCS_CFG_BITS 32
`define QCS_CFG_RESET 32'h1f00_0004
`define QCS_CFG_MAX_HI 31
`define QCS_CFG_MAX_LO 24
`define QCS_CFG_INIT_HI 23
`define QCS_CFG_INIT_LO 16
`define QCS_CFG_TMR_HI 15
`define QCS_CFG_TMR_LO 8
`define QCS_CFG_FORCE 5
`define QCS_CFG_X1_HI 4
`define QCS_CFG_X1_LO 3
`define QCS_CFG_DEB 2
`define QCS_CFG_WRAP 1
`define QCS_CFG_GEAR 0
`define QCS_SPI_CNT_MAX 6'h21
`define QCS_SPI_CNT_FULL 6'h20
`define QCS_CNT_MIN 8'h00
`define QCS_THR_MAX 5'h1f
`define QCS_THR_MIN 5'h00
`define QCS_GEAR_HI 4
`define QCS_GEAR_LO 3
`define QCS_GEAR_FAST 2'h2
`define QCS_FRAME_REST 4'h9
`define QCS_UART_IDLE 1'b1
`define QCS_UART_START 1'b0
`define QCS_UART_STOP 1'b1

`endif

/* File: core/qcs_pkg.sv */
// Purpose: Types shared by the quadrature counter
// Assumes: Configuration word layout fixed by the constants header
// Notes: The struct mirrors the configuration word bit for bit
`include "qcs_defines.svh"
package qcs_pkg;

  typedef struct packed {
    logic [7:0] maxVal;
    logic [7:0] initVal;
    logic [7:0] gearTimer;
    logic [1:0] unused;
    logic forceHalf;
    logic [1:0] x1Code;
    logic debounceEn;
    logic wrapEn;
    logic gearEn;
  } qcs_cfg_type;

  typedef struct packed {
    logic chanA;
    logic chanB;
    logic halfRatePin;
    logic spiCsN;
    logic spiSck;
    logic spiSdi;
  } qcs_pins_type;

  typedef struct packed {
    logic quad;
    logic dbl;
    logic single;
    logic fwd;
  } qcs_pulse_type;

endpackage : qcs_pkg

/* File: core/qcs_counter.sv */
// Purpose: Quadrature driven 8-bit counter with parallel, serial and PWM outputs, configured over SPI
// Assumes: All pins asynchronous to clk; SPI clock far slower than clk
// Notes: Serial frames leave back to back, one bit per clk, fed through a small buffer
// Functional notes
// - Eight-bit counter steps up or down on decoded quadrature transitions.
// - Parallel output shows the low five counter bits.
// - Counter sent as 8N1 frame, one bit per system clock.
// - Direction output shows forward or backward progression.
// - PWM duty cycle proportional to counter value.
// - PWM period follows configured maximum value.
// - With debounce, a reversal needs a second pulse in that direction.
// - With wrap, counter rolls between maximum and minimum.
// - Gearbox picks quad rate pulses at high channel speed, else the single or double rate set by pin and force bit.
// - Five-bit threshold rises per quad pulse off a tick, falls per tick without a quad pulse; divided by eight selects gear.
// - Gearbox timer value sets cycles between threshold decrements.
// - Pin high or force bit makes counter update on double-rate pulses.
// - Single-rate code selects which transitions make single-rate pulses.
// - Reset defaults form a debounced five-bit counter, maximum 31.
// - Configuration over SPI mode 0, MSB first, active-low select, 32 bits.
// - Word bits 31..24 maximum, 23..16 initial, 15..8 gearbox timer.
// - Bit 5 force, 4..3 single code, 2 debounce, 1 wrap, 0 gearbox.
// - Accepted configuration loads counter with its initial value.
`include "qcs_defines.svh"
module qcs_counter
  import qcs_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic chanA, // Quadrature channel A
  input wire logic chanB, // Quadrature channel B
  input wire logic halfRatePin, // Update on double-rate pulses when high
  input wire logic spiCsN, // SPI chip select, active low
  input wire logic spiSck, // SPI clock
  input wire logic spiSdi, // SPI data in
  output logic uartTx, // Serial count stream
  output logic pwmOut, // PWM of the count
  output logic dirOut, // Direction, high is forward
  output logic [4:0] countOut // Low five counter bits
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("FIFO_DEPTH must be at least 2");
  end

  // Input synchronisers
  qcs_pins_type pinsRaw, sync1_r, sync2_r, pinsPrev_r;
  assign pinsRaw = '{chanA, chanB, halfRatePin, spiCsN, spiSck, spiSdi};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      sync2_r <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      pinsPrev_r <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    end else begin
      sync1_r <= pinsRaw;
      sync2_r <= sync1_r;
      pinsPrev_r <= sync2_r;
    end
  end

  // SPI configuration receiver
  qcs_cfg_type cfg_r, cfg_nxt;
  logic [31:0] spiShift_r, spiShift_nxt;
  logic [5:0] spiCnt_r, spiCnt_nxt;
  logic cfgLoad_r, cfgLoad_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    spiShift_nxt = spiShift_r;
    spiCnt_nxt = spiCnt_r;
    cfgLoad_nxt = 1'b0;
    if (sync2_r.spiCsN) begin
      if (!pinsPrev_r.spiCsN && spiCnt_r == `QCS_SPI_CNT_FULL) begin
        cfg_nxt = qcs_cfg_type'(spiShift_r);
        cfgLoad_nxt = 1'b1;
      end
      spiCnt_nxt = 6'h00;
    end else if (sync2_r.spiSck && !pinsPrev_r.spiSck) begin
      spiShift_nxt = {spiShift_r[30:0], sync2_r.spiSdi};
      if (spiCnt_r != `QCS_SPI_CNT_MAX) begin
        spiCnt_nxt = spiCnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= qcs_cfg_type'(`QCS_CFG_RESET);
      spiShift_r <= 32'h0000_0000;
      spiCnt_r <= 6'h00;
      cfgLoad_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      spiShift_r <= spiShift_nxt;
      spiCnt_r <= spiCnt_nxt;
      cfgLoad_r <= cfgLoad_nxt;
    end
  end

  // Quadrature decoder
  qcs_pulse_type pulse;
  logic [1:0] grayNow, grayOld, binNow, binOld;

  always_comb begin
    grayNow = {sync2_r.chanA, sync2_r.chanB};
    grayOld = {pinsPrev_r.chanA, pinsPrev_r.chanB};
    binNow = {grayNow[1], grayNow[1] ^ grayNow[0]};
    binOld = {grayOld[1], grayOld[1] ^ grayOld[0]};
    pulse.quad = (grayNow ^ grayOld) == 2'b01 || (grayNow ^ grayOld) == 2'b10;
    pulse.fwd = binNow == binOld + 2'b01;
    pulse.single = pulse.quad && grayNow == cfg_r.x1Code;
    pulse.dbl = pulse.quad && (grayNow == cfg_r.x1Code || grayNow == ~cfg_r.x1Code);
  end

  // Gearbox, debounce and counter
  logic [4:0] thr_r, thr_nxt;
  logic [7:0] tmr_r, tmr_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic dir_r, dir_nxt;
  logic revPend_r, revPend_nxt;
  logic halfRate, stepPulse, accept;

  always_comb begin
    thr_nxt = thr_r;
    tmr_nxt = tmr_r;
    if (tmr_r == 8'h00) begin
      tmr_nxt = cfg_r.gearTimer;
    end else begin
      tmr_nxt = tmr_r - 8'h01;
    end
    if (pulse.quad && !(tmr_r == 8'h00)) begin
      if (thr_r != `QCS_THR_MAX) begin
        thr_nxt = thr_r + 5'h01;
      end
    end else if (tmr_r == 8'h00 && !pulse.quad) begin
      if (thr_r != `QCS_THR_MIN) begin
        thr_nxt = thr_r - 5'h01;
      end
    end
    halfRate = sync2_r.halfRatePin || cfg_r.forceHalf;
    if (cfg_r.gearEn && thr_r[`QCS_GEAR_HI:`QCS_GEAR_LO] >= `QCS_GEAR_FAST) begin
      stepPulse = pulse.quad;
    end else if (halfRate) begin
      stepPulse = pulse.dbl;
    end else begin
      stepPulse = pulse.single;
    end

    dir_nxt = dir_r;
    revPend_nxt = revPend_r;
    accept = 1'b0;
    if (stepPulse) begin
      if (pulse.fwd == dir_r) begin
        accept = 1'b1;
        revPend_nxt = 1'b0;
      end else if (cfg_r.debounceEn && !revPend_r) begin
        revPend_nxt = 1'b1;
      end else begin
        accept = 1'b1;
        dir_nxt = pulse.fwd;
        revPend_nxt = 1'b0;
      end
    end

    cnt_nxt = cnt_r;
    if (cfgLoad_r) begin
      cnt_nxt = cfg_r.initVal;
    end else if (accept && pulse.fwd) begin
      if (cnt_r >= cfg_r.maxVal) begin
        cnt_nxt = cfg_r.wrapEn ? `QCS_CNT_MIN : cfg_r.maxVal;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end else if (accept) begin
      if (cnt_r == `QCS_CNT_MIN) begin
        cnt_nxt = cfg_r.wrapEn ? cfg_r.maxVal : `QCS_CNT_MIN;
      end else begin
        cnt_nxt = cnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      thr_r <= `QCS_THR_MIN;
      tmr_r <= 8'h00;
      cnt_r <= `QCS_CNT_MIN;
      dir_r <= 1'b1;
      revPend_r <= 1'b0;
    end else begin
      thr_r <= thr_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      revPend_r <= revPend_nxt;
    end
  end

  // Two-entry buffer between the count and the serial shifter
  logic [7:0] fifoMem_r [FIFO_DEPTH];
  logic [7:0] fifoMem_nxt [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [PTR_W:0] fill_r, fill_nxt;
  logic inValid, inReady, outValid, outReady, push, pop;

  assign inValid = 1'b1;
  assign inReady = fill_r != (PTR_W + 1)'(FIFO_DEPTH);
  assign outValid = fill_r != '0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    fifoMem_nxt = fifoMem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    if (push) begin
      fifoMem_nxt[wrPtr_r] = cnt_r;
      wrPtr_nxt = (wrPtr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wrPtr_r + PTR_W'(1);
    end
    if (pop) begin
      rdPtr_nxt = (rdPtr_r == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rdPtr_r + PTR_W'(1);
    end
    fill_nxt = fill_r + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifoMem_r[i] <= 8'h00;
      end
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r <= '0;
    end else begin
      fifoMem_r <= fifoMem_nxt;
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Serial shifter, one bit per clock
  logic [8:0] txShift_r, txShift_nxt;
  logic [3:0] txLeft_r, txLeft_nxt;
  logic tx_nxt;

  assign outReady = txLeft_r == 4'h0;

  always_comb begin
    txShift_nxt = txShift_r;
    txLeft_nxt = txLeft_r;
    tx_nxt = `QCS_UART_IDLE;
    if (txLeft_r != 4'h0) begin
      tx_nxt = txShift_r[0];
      txShift_nxt = {1'b1, txShift_r[8:1]};
      txLeft_nxt = txLeft_r - 4'h1;
    end else if (outValid) begin
      tx_nxt = `QCS_UART_START;
      txShift_nxt = {`QCS_UART_STOP, fifoMem_r[rdPtr_r]};
      txLeft_nxt = `QCS_FRAME_REST;
    end
  end

  // PWM, period set by the maximum value
  logic [7:0] pwmCnt_r, pwmCnt_nxt;

  always_comb begin
    pwmCnt_nxt = (pwmCnt_r >= cfg_r.maxVal) ? 8'h00 : pwmCnt_r + 8'h01;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txShift_r <= 9'h1ff;
      txLeft_r <= 4'h0;
      uartTx <= `QCS_UART_IDLE;
      pwmCnt_r <= 8'h00;
      pwmOut <= 1'b0;
      dirOut <= 1'b1;
      countOut <= 5'h00;
    end else begin
      txShift_r <= txShift_nxt;
      txLeft_r <= txLeft_nxt;
      uartTx <= tx_nxt;
      pwmCnt_r <= pwmCnt_nxt;
      pwmOut <= pwmCnt_r < cnt_r;
      dirOut <= dir_r;
      countOut <= cnt_r[4:0];
    end
  end

endmodule : qcs_counter

/* File: tb/qcs_counter_sva.sv */
// Purpose: Port-level checks of the quadrature counter
// Assumes: Bench keeps maximum at 31 or below and holds each channel state six cycles
// Notes: Bound to every counter instance
module qcs_counter_sva (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic chanA, // Channel A
  input wire logic chanB, // Channel B
  input wire logic spiCsN, // Select
  input wire logic uartTx, // Serial out
  input wire logic pwmOut, // PWM
  input wire logic dirOut, // Direction
  input wire logic [4:0] countOut // Count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] csHist_r;
  logic [3:0] pos_r;
  logic [5:0] lowRun_r;
  logic cfgQuiet;
  assign cfgQuiet = &csHist_r;
  // Frame position tracker starts at the first start bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csHist_r <= 12'hfff;
      pos_r <= 4'hf;
      lowRun_r <= 6'h00;
    end else begin
      csHist_r <= {csHist_r[10:0], spiCsN};
      pos_r <= (pos_r == 4'hf) ? (uartTx ? 4'hf : 4'h1) : ((pos_r == 4'h9) ? 4'h0 : pos_r + 4'h1);
      lowRun_r <= (pwmOut || countOut == 5'h00) ? 6'h00 : lowRun_r + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence chanQuiet;
    $stable({chanA, chanB}) [*6];
  endsequence
  sequence chanMoved;
    $past({chanA, chanB}, 3) != $past({chanA, chanB}, 7);
  endsequence
  chk_count_quiet: assert property (chanQuiet ##0 cfgQuiet |=> $stable({countOut, dirOut}))
    else $error("count moved idle");
  chk_count_cause: assert property ($changed({countOut, dirOut}) && cfgQuiet |-> chanMoved)
    else $error("count moved without step");
  chk_dir_cause: assert property ($changed(dirOut) && cfgQuiet |->
    dirOut == ($past({chanA, chanB}, 3) == {$past(chanB, 7), ~$past(chanA, 7)}))
    else $error("direction wrong");
  chk_step_one: assert property ($changed(countOut) && cfgQuiet |->
    (5'(countOut - $past(countOut)) inside {5'h01, 5'h1f}) || countOut == 5'h00 || $past(countOut) == 5'h00)
    else $error("count step not one");
  chk_uart_start: assert property (pos_r == 4'h0 |-> !uartTx)
    else $error("start bit missing");
  chk_uart_stop: assert property (pos_r == 4'h9 |-> uartTx)
    else $error("stop bit missing");
  chk_pwm_idle: assert property (countOut == 5'h00 [*3] |-> !pwmOut)
    else $error("pwm high at zero");
  chk_pwm_active: assert property (lowRun_r < 6'd40)
    else $error("pwm stuck low");
endmodule : qcs_counter_sva
bind qcs_counter qcs_counter_sva chk (.clk(clk), .rstn(rstn), .chanA(chanA), .chanB(chanB), .spiCsN(spiCsN),
  .uartTx(uartTx), .pwmOut(pwmOut), .dirOut(dirOut), .countOut(countOut));

/* File: tb/qcs_partner.sv */
// Purpose: Encoder and SPI host driving the counter pins
// Assumes: Pins change 1 ns after a clk edge
// Notes: Data line shows the inverse of its last bit outside frames
module qcs_partner (
  input wire logic clk, // Clock
  output logic chanA, // Channel A
  output logic chanB, // Channel B
  output logic spiCsN, // Select
  output logic spiSck, // SPI clock
  output logic spiSdi // SPI data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    chanA = 1'b0;
    chanB = 1'b0;
    spiCsN = 1'b1;
    spiSck = 1'b0;
    spiSdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic step(input logic fwd);
    logic [1:0] n;
    n = fwd ? {chanB, ~chanA} : {~chanB, chanA};
    tick(1);
    {chanA, chanB} = n;
    tick(5);
  endtask : step
  task automatic sendCfg(input logic [31:0] w, input int nBits);
    tick(1);
    spiCsN = 1'b0;
    for (int i = 31; i > 31 - nBits; i--) begin
      spiSdi = w[i];
      tick(4);
      spiSck = 1'b1;
      tick(4);
      spiSck = 1'b0;
    end
    tick(4);
    spiCsN = 1'b1;
    spiSdi = ~spiSdi;
    tick(4);
  endtask : sendCfg
endmodule : qcs_partner

/* File: tb/tb_qcs_counter.sv */
// Purpose: Random walk and configuration test of the quadrature counter
// Assumes: Maximum kept at 31 or below; gearbox only in the closing scenario
// Notes: A model function predicts count and direction per step
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, got, exp); end end
module tb_qcs_counter import qcs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic halfRatePin = 1'b0;
  logic chanA, chanB, spiCsN, spiSck, spiSdi, uartTx, pwmOut, dirOut, accDir, pend, fwd;
  logic [4:0] countOut;
  logic [3:0] rxPos;
  logic [7:0] rxShift, rxByte, expCnt;
  logic [1:0] nxt;
  logic [4:0] base;
  qcs_cfg_type cfg;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 7778;
  always #2.5 clk = ~clk;
  qcs_counter dut (.clk(clk), .rstn(rstn), .chanA(chanA), .chanB(chanB), .halfRatePin(halfRatePin),
    .spiCsN(spiCsN), .spiSck(spiSck), .spiSdi(spiSdi), .uartTx(uartTx), .pwmOut(pwmOut), .dirOut(dirOut),
    .countOut(countOut));
  qcs_partner partner (.clk(clk), .chanA(chanA), .chanB(chanB), .spiCsN(spiCsN), .spiSck(spiSck), .spiSdi(spiSdi));
  // Receiver sampling one bit per clk
  always @(posedge clk) begin
    if (!rstn) rxPos <= 4'hf;
    else if (rxPos == 4'hf) rxPos <= uartTx ? 4'hf : 4'h1;
    else begin
      if (rxPos >= 4'h1 && rxPos <= 4'h8) rxShift <= {uartTx, rxShift[7:1]};
      if (rxPos == 4'h9) rxByte <= rxShift;
      rxPos <= (rxPos == 4'h9) ? 4'h0 : rxPos + 4'h1;
    end
  end
  function automatic void modelStep(input logic up, input logic [1:0] n);
    if (n != cfg.x1Code && !((halfRatePin || cfg.forceHalf) && n == ~cfg.x1Code)) return;
    if (cfg.debounceEn && up != accDir && !pend) begin
      pend = 1'b1;
      return;
    end
    pend = 1'b0;
    accDir = up;
    if (up) expCnt = (expCnt >= cfg.maxVal) ? (cfg.wrapEn ? 8'h00 : cfg.maxVal) : expCnt + 8'h01;
    else expCnt = (expCnt == 8'h00) ? (cfg.wrapEn ? cfg.maxVal : 8'h00) : expCnt - 8'h01;
  endfunction : modelStep
  task automatic run(input int k);
    logic [7:0] hi;
    repeat (k) begin
      fwd = (($random(seed) & 3) != 0);
      nxt = fwd ? {chanB, ~chanA} : {~chanB, chanA};
      partner.step(fwd);
      modelStep(fwd, nxt);
      `CHK({dirOut, countOut}, {accDir, expCnt[4:0]})
    end
    repeat (40) @(posedge clk);
    #1;
    `CHK(rxByte, expCnt)
    // One PWM period holds exactly count high cycles
    hi = 8'h00;
    repeat (cfg.maxVal + 1) begin
      @(posedge clk);
      #1;
      hi = hi + 8'(pwmOut);
    end
    `CHK(hi, expCnt)
  endtask : run
  task automatic results;
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    #300us;
    fail_count++;
    results();
  end
  initial begin
    cfg = qcs_cfg_type'(32'h1f00_0004);
    expCnt = 8'h00;
    accDir = 1'b1;
    pend = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    `CHK({dirOut, countOut, pwmOut, uartTx}, {1'b1, 5'h00, 1'b0, 1'b1})
    run(24);
    for (int i = 0; i < 8; i++) begin
      cfg = qcs_cfg_type'($random(seed));
      cfg.maxVal = 8'h02 + 8'($random(seed) & 3);
      cfg.initVal = i[0] ? 8'h00 : cfg.maxVal;
      cfg.x1Code = 2'(i);
      cfg.forceHalf = i[2];
      cfg.wrapEn = i[1];
      cfg.gearEn = 1'b0;
      halfRatePin = 1'($random(seed));
      partner.sendCfg(cfg, 32);
      repeat (4) @(posedge clk);
      #1;
      expCnt = cfg.initVal;
      `CHK(countOut, expCnt[4:0])
      run(48);
    end
    partner.sendCfg(32'h1f1f_0004, 31);
    repeat (4) @(posedge clk);
    #1;
    `CHK(countOut, expCnt[4:0])
    // Gearbox: fast steps climb to quad rate, a zero timer pins it at single rate
    halfRatePin = 1'b0;
    partner.sendCfg(32'h1f00_ff01, 32);
    repeat (4) @(posedge clk);
    #1;
    repeat (24) partner.step(1'b1);
    base = countOut;
    repeat (4) partner.step(1'b1);
    `CHK(5'(countOut - base), 5'h04)
    partner.sendCfg(32'h1f00_0001, 32);
    repeat (320) @(posedge clk);
    #1;
    repeat (8) partner.step(1'b1);
    `CHK(countOut, 5'h02)
    results();
  end
endmodule : tb_qcs_counter
